// ### core/jis_tap.sv
// How it works
// [RL1] extest and sample instructions select the one-bit bypass register
// [RL2] id word: 4-bit version, 16-bit part, 11-bit maker, constant bit
// [RL3] id fields packed msb-first, version in top bits
// [RL4] id bit zero always one
// [RL5] secure device returns zeros on readback
// [RL6] security bit and config change only by a program operation
// [RL7] instruction register is exactly 10 bits
// [RL8] idcode instruction puts id register between tdi and tdo
// [RL9] id shifts out bit zero first, one bit per test clock
`timescale 1ns/1ns
`default_nettype none
module jis_tap (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      tdo,
    output logic      tdo_oe,
    output logic      secure
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] tck_sync_q;
    logic [1:0] tms_sync_q;
    logic [1:0] tdi_sync_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_sync_q <= 3'h0;
            tms_sync_q <= 2'h0;
            tdi_sync_q <= 2'h0;
        end else begin
            tck_sync_q <= {tck_sync_q[1:0], tck};
            tms_sync_q <= {tms_sync_q[0], tms};
            tdi_sync_q <= {tdi_sync_q[0], tdi};
        end
    end

    wire tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
    wire tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
    wire tms_s    = tms_sync_q[1];
    wire tdi_s    = tdi_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // tap state machine
    jis_pkg::jis_state_t state_q;
    jis_pkg::jis_state_t state_d;

    function automatic jis_pkg::jis_state_t next_state(input jis_pkg::jis_state_t s, input logic m);
        case (s)
            jis_pkg::JIS_TLR:   next_state = m ? jis_pkg::JIS_TLR   : jis_pkg::JIS_RTI;
            jis_pkg::JIS_RTI:   next_state = m ? jis_pkg::JIS_SELDR : jis_pkg::JIS_RTI;
            jis_pkg::JIS_SELDR: next_state = m ? jis_pkg::JIS_SELIR : jis_pkg::JIS_CAPDR;
            jis_pkg::JIS_CAPDR: next_state = m ? jis_pkg::JIS_EX1DR : jis_pkg::JIS_SHDR;
            jis_pkg::JIS_SHDR:  next_state = m ? jis_pkg::JIS_EX1DR : jis_pkg::JIS_SHDR;
            jis_pkg::JIS_EX1DR: next_state = m ? jis_pkg::JIS_UPDR  : jis_pkg::JIS_PDR;
            jis_pkg::JIS_PDR:   next_state = m ? jis_pkg::JIS_EX2DR : jis_pkg::JIS_PDR;
            jis_pkg::JIS_EX2DR: next_state = m ? jis_pkg::JIS_UPDR  : jis_pkg::JIS_SHDR;
            jis_pkg::JIS_UPDR:  next_state = m ? jis_pkg::JIS_SELDR : jis_pkg::JIS_RTI;
            jis_pkg::JIS_SELIR: next_state = m ? jis_pkg::JIS_TLR   : jis_pkg::JIS_CAPIR;
            jis_pkg::JIS_CAPIR: next_state = m ? jis_pkg::JIS_EX1IR : jis_pkg::JIS_SHIR;
            jis_pkg::JIS_SHIR:  next_state = m ? jis_pkg::JIS_EX1IR : jis_pkg::JIS_SHIR;
            jis_pkg::JIS_EX1IR: next_state = m ? jis_pkg::JIS_UPIR  : jis_pkg::JIS_PIR;
            jis_pkg::JIS_PIR:   next_state = m ? jis_pkg::JIS_EX2IR : jis_pkg::JIS_PIR;
            jis_pkg::JIS_EX2IR: next_state = m ? jis_pkg::JIS_UPIR  : jis_pkg::JIS_SHIR;
            jis_pkg::JIS_UPIR:  next_state = m ? jis_pkg::JIS_SELDR : jis_pkg::JIS_RTI;
            default:            next_state = jis_pkg::JIS_TLR;
        endcase
    endfunction : next_state

    assign state_d = tck_rise ? next_state(state_q, tms_s) : state_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= jis_pkg::JIS_TLR;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction register
    logic [9:0] ir_sh_q;
    logic [9:0] ir_q;

    wire in_tlr  = state_q == jis_pkg::JIS_TLR;
    wire cap_ir  = tck_rise & (state_q == jis_pkg::JIS_CAPIR);
    wire sh_ir   = tck_rise & (state_q == jis_pkg::JIS_SHIR);
    wire upd_ir  = tck_rise & (state_q == jis_pkg::JIS_UPIR);

    // 10-bit shift path, tdi enters at the top
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_sh_q <= 10'h000;
            ir_q    <= jis_pkg::IR_RESET_VAL;
        end else begin
            if (cap_ir) begin
                ir_sh_q <= jis_pkg::IR_CAPTURE;
            end else if (sh_ir) begin
                ir_sh_q <= {tdi_s, ir_sh_q[9:1]}; // RL7
            end
            // test-logic-reset forces the id instruction back in
            if (in_tlr) begin
                ir_q <= jis_pkg::IR_RESET_VAL;
            end else if (upd_ir) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction decode
    wire sel_id   = ir_q == jis_pkg::IR_IDCODE;                                    // RL8
    wire sel_prog = ir_q == jis_pkg::IR_PROGRAM;
    wire sel_rb   = ir_q == jis_pkg::IR_READBACK;
    wire sel_byp  = ~(sel_id | sel_prog | sel_rb);  // bypass, extest, sample, unknown; RL1

    ////////////////////////////////////////////////////////////////////////
    // configuration store
    logic [32:0] cfg_rd;
    logic        mem_we;

    assign mem_we = tck_rise & (state_q == jis_pkg::JIS_UPDR) & sel_prog; // RL6

    logic [32:0] dr_q;

    jis_cfg_store u_store (
        .clk     (core_clk),
        .wr_en   (mem_we),
        .wr_data (dr_q),
        .rd_data (cfg_rd)
    );

    wire sec_bit = cfg_rd[jis_pkg::SEC_POS];

    ////////////////////////////////////////////////////////////////////////
    // data register: one shifter, length set by the instruction
    function automatic logic [32:0] dr_shift(input logic [32:0] d, input logic b,
                                             input logic byp, input logic prog);
        logic [32:0] r;
        r = {b, d[32:1]};
        if (byp) r = {32'h0, b};                                  // RL1
        else if (!prog) r = {1'b0, b, d[31:1]};                   // RL9
        dr_shift = r;
    endfunction : dr_shift

    wire cap_dr = tck_rise & (state_q == jis_pkg::JIS_CAPDR);
    wire sh_dr  = tck_rise & (state_q == jis_pkg::JIS_SHDR);

    // capture values per selected register
    wire [32:0] cap_rb  = sec_bit ? 33'h0 : {1'b0, cfg_rd[31:0]};            // RL5
    wire [32:0] cap_val = sel_id ? {1'b0, jis_pkg::ID_WORD} :              // RL2 RL3 RL4
                          sel_rb ? cap_rb : 33'h0;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dr_q <= 33'h0;
        end else if (cap_dr) begin
            dr_q <= cap_val;
        end else if (sh_dr) begin
            dr_q <= dr_shift(dr_q, tdi_s, sel_byp, sel_prog);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tdo and its enable change on the falling test clock
    wire in_shift = (state_q == jis_pkg::JIS_SHDR) | (state_q == jis_pkg::JIS_SHIR);
    wire tdo_src  = (state_q == jis_pkg::JIS_SHIR) ? ir_sh_q[0] : dr_q[0];       // RL9

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
            secure <= 1'b0;
        end else begin
            if (tck_fall) begin
                tdo    <= tdo_src;
                tdo_oe <= in_shift;
            end
            secure <= sec_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // id fields checked one by one against the package values
    a_id_capture: assert property (cap_dr && sel_id |=> dr_q[31:28] == jis_pkg::ID_VERSION // RL2 RL3 RL4
                                   && dr_q[27:12] == jis_pkg::ID_PART
                                   && dr_q[11:1] == jis_pkg::ID_MAKER && dr_q[0] && !dr_q[32])
        else $error("id capture wrong");
    a_id_shift_len: assert property (sh_dr && sel_id |=> dr_q[31] == $past(tdi_s) && !dr_q[32]) // RL8
        else $error("id register length wrong");
    a_bypass_ext: assert property (sh_dr && (ir_q == jis_pkg::IR_EXTEST || ir_q == jis_pkg::IR_SAMPLE)
                                   |=> dr_q == {32'h0, $past(tdi_s)}) // RL1
        else $error("extest or sample not on bypass");
    a_secure_blank: assert property (cap_dr && sel_rb && sec_bit |=> dr_q == 33'h0) // RL5
        else $error("readback leaked while secure");
    a_secure_hold: assert property (!mem_we |-> ##2 $stable(sec_bit)) // RL6
        else $error("security bit changed without programming");
    a_ir_len: assert property (sh_ir |=> ir_sh_q[9] == $past(tdi_s) && ir_sh_q[8:0] == $past(ir_sh_q[9:1])) // RL7
        else $error("instruction shift wrong");
    a_tdo_lsb: assert property (tck_fall && state_q == jis_pkg::JIS_SHDR |=> tdo == $past(dr_q[0]) && tdo_oe) // RL9
        else $error("tdo not lsb of data register");
    a_tdo_quiet: assert property (tck_fall && !in_shift |=> !tdo_oe ##1 !tdo_oe) // RL9
        else $error("tdo driven outside shift");
    a_tdo_ir: assert property (tck_fall && state_q == jis_pkg::JIS_SHIR |=> tdo == $past(ir_sh_q[0]) && tdo_oe) // RL7
        else $error("tdo not lsb of instruction shifter");
    a_ir_update: assert property (upd_ir |=> ir_q == $past(ir_sh_q)) // RL7
        else $error("instruction not taken on update");
    a_tlr_idcode: assert property (in_tlr |=> ir_q == jis_pkg::IR_RESET_VAL) // RL8
        else $error("reset state lost id instruction");
    a_byp_capture: assert property (cap_dr && sel_byp |=> dr_q == 33'h0) // RL1
        else $error("bypass capture not zero");
    a_rb_open: assert property (cap_dr && sel_rb && !sec_bit |=> dr_q == {1'b0, $past(cfg_rd[31:0])}) // RL6
        else $error("open readback wrong");

    // main scenarios
    c_id_read: cover property (cap_dr && sel_id ##[1:40] sh_dr);
    c_sec_readback: cover property (cap_dr && sel_rb && sec_bit);
    c_program: cover property (mem_we);
    c_bypass_shift: cover property (sh_dr && sel_byp);
    c_reprogram_clear: cover property (mem_we && sec_bit && !dr_q[jis_pkg::SEC_POS]);
endmodule : jis_tap
`default_nettype wire

// ### core/jis_pkg.sv
package jis_pkg;

    // instruction register
    localparam int unsigned IR_LEN          = 10;
    localparam logic [9:0]  IR_CAPTURE      = 10'h001;
    localparam logic [9:0]  IR_EXTEST       = 10'h000;
    localparam logic [9:0]  IR_SAMPLE       = 10'h055;
    localparam logic [9:0]  IR_IDCODE       = 10'h059;
    localparam logic [9:0]  IR_BYPASS       = 10'h3FF;
    localparam logic [9:0]  IR_PROGRAM      = 10'h2A0;
    localparam logic [9:0]  IR_READBACK     = 10'h2A1;
    localparam logic [9:0]  IR_RESET_VAL    = IR_IDCODE;

    // identification word, field values arbitrary
    localparam logic [3:0]  ID_VERSION      = 4'h1;
    localparam logic [15:0] ID_PART         = 16'h1234;
    localparam logic [10:0] ID_MAKER        = 11'h155;
    localparam logic        ID_LSB          = 1'b1;
    localparam int unsigned ID_VER_POS      = 28;
    localparam int unsigned ID_PART_POS     = 12;
    localparam int unsigned ID_MAKER_POS    = 1;
    localparam logic [31:0] ID_WORD         = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

    // configuration store: security bit above a 32-bit config word
    localparam int unsigned CFG_W           = 32;
    localparam int unsigned SEC_POS         = 32;
    localparam logic [32:0] CFG_ERASED      = 33'h0FFFFFFFF;

    // data register lengths
    localparam int unsigned DR_LEN_BYP      = 1;
    localparam int unsigned DR_LEN_ID       = 32;
    localparam int unsigned DR_LEN_PROG     = 33;

    // tap controller states
    typedef enum logic [3:0] {
        JIS_TLR   = 4'h0, JIS_RTI   = 4'h1, JIS_SELDR = 4'h3, JIS_CAPDR = 4'h2,
        JIS_SHDR  = 4'h6, JIS_EX1DR = 4'h7, JIS_PDR   = 4'h5, JIS_EX2DR = 4'h4,
        JIS_UPDR  = 4'hC, JIS_SELIR = 4'hD, JIS_CAPIR = 4'hF, JIS_SHIR  = 4'hE,
        JIS_EX1IR = 4'hA, JIS_PIR   = 4'hB, JIS_EX2IR = 4'h9, JIS_UPIR  = 4'h8
    } jis_state_t;

endpackage : jis_pkg

// ### core/jis_cfg_store.sv
`timescale 1ns/1ns
`default_nettype none
// non-volatile model: contents survive core reset, change only on write
module jis_cfg_store (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [32:0] wr_data,
    output logic      [32:0] rd_data
);
    logic [32:0] cell_q = jis_pkg::CFG_ERASED;

    // storage, rewritten only by a program operation
    always_ff @(posedge clk) begin
        if (wr_en) begin
            cell_q <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clk) begin
        rd_data <= cell_q;
    end
endmodule : jis_cfg_store
`default_nettype wire

// ### verif/jis_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// test controller model; tck idles low outside frames
module jis_ctl_model (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic oe_all;

    // idle levels at time zero
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;  // pull-up level
        oe_all = 1'h1;
    end

    // one tck period, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62;
        q = tdo;
        tck = 1'h1;
        #63;
        tck = 1'h0;
    endtask : step

    // tms sequence, lsb first
    task automatic walk(input int n, input logic [7:0] seq);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'h1, q);  // tdi idles at its pull-up level
        end
    endtask : walk

    // shift lsb first, leave on last bit, then update and idle
    task automatic shift(input int n, input logic [32:0] din, output logic [32:0] dout);
        logic q;
        dout = '0;
        oe_all = 1'h1;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            oe_all = oe_all & tdo_oe;
        end
        walk(2, 8'h01);
    endtask : shift

    // instruction load of exactly ten bits
    task automatic ir(input logic [9:0] code, output logic [9:0] cap);
        logic [32:0] q;
        walk(4, 8'h03);
        shift(10, {23'h0, code}, q);
        cap = q[9:0];
    endtask : ir

    task automatic dr(input int n, input logic [32:0] din, output logic [32:0] dout);
        walk(3, 8'h01);
        shift(n, din, dout);
    endtask : dr

    // five ones reach reset, then idle
    task automatic tlr();
        walk(6, 8'h1F);
    endtask : tlr
endmodule : jis_ctl_model
`default_nettype wire

// ### verif/jis_tap_tb.sv
`timescale 1ns/1ns
`default_nettype none
module jis_tap_tb;
    logic        core_clk;
    logic        arst_n;
    wire         tck;
    wire         tms;
    wire         tdi;
    logic        tdo;
    logic        tdo_oe;
    logic        secure;
    int          failures = 0;
    int          check_count = 0;
    logic [32:0] q;
    logic [9:0]  c;

    jis_tap jis_tap_inst (.core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .secure(secure));
    jis_ctl_model jis_ctl_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    always #4 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // program word and security bit, then read back
    task automatic prog(input logic [32:0] v);
        jis_ctl_model_inst.ir(jis_pkg::IR_PROGRAM, c);
        jis_ctl_model_inst.dr(33, v, q);
        jis_ctl_model_inst.ir(jis_pkg::IR_READBACK, c);
        jis_ctl_model_inst.dr(32, 33'h0, q);
    endtask : prog

    ////////////////////////////////////////////////////////////////////////
    // id word shifted out lsb first
    task automatic t_idcode();
        jis_ctl_model_inst.dr(32, 33'h0, q);
        chk("id word", q, {1'h0, jis_pkg::ID_VERSION, jis_pkg::ID_PART, jis_pkg::ID_MAKER, 1'h1});
        chk("id version", q[31:28], jis_pkg::ID_VERSION);
        chk("id bit zero", q[0], 1'h1);
        chk("id tdo enable", jis_ctl_model_inst.oe_all, 1'h1);
    endtask : t_idcode

    // ten-bit capture pattern, then explicit id select
    task automatic t_irlen();
        jis_ctl_model_inst.ir(jis_pkg::IR_IDCODE, c);
        chk("ir capture", c, jis_pkg::IR_CAPTURE);
        jis_ctl_model_inst.dr(32, 33'h0, q);
        chk("id selected", q[31:0], jis_pkg::ID_WORD);
    endtask : t_irlen

    // one-bit delay through bypass for each code
    task automatic t_bypass();
        logic [9:0] codes [3];
        codes = '{jis_pkg::IR_EXTEST, jis_pkg::IR_SAMPLE, jis_pkg::IR_BYPASS};
        foreach (codes[i]) begin
            jis_ctl_model_inst.ir(codes[i], c);
            jis_ctl_model_inst.dr(8, 33'hA5, q);
            chk("bypass path", q[7:0], 8'h4A);
        end
    endtask : t_bypass

    // security set, survives resets, cleared by reprogram
    task automatic t_secure();
        prog({1'h0, 32'h5AC30F96});
        chk("readback open", q[31:0], 32'h5AC30F96);
        chk("secure clear", secure, 1'h0);
        prog({1'h1, 32'h3C3CA5A5});
        chk("readback locked", q[31:0], 32'h0);
        chk("secure set", secure, 1'h1);
        @(posedge core_clk);
        #1 arst_n = 1'h0;
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'h1;
        repeat (3) @(posedge core_clk);
        #1 chk("secure kept", secure, 1'h1);
        jis_ctl_model_inst.tlr();
        jis_ctl_model_inst.ir(jis_pkg::IR_READBACK, c);
        jis_ctl_model_inst.dr(32, 33'h0, q);
        chk("readback still locked", q[31:0], 32'h0);
        prog({1'h0, 32'h12348765});
        chk("secure cleared", secure, 1'h0);
        chk("readback reopened", q[31:0], 32'h12348765);
    endtask : t_secure

    ////////////////////////////////////////////////////////////////////////
    // reset, then scenarios in turn
    initial begin
        core_clk = 1'h0;
        arst_n = 1'h0;
        repeat (8) @(posedge core_clk);
        #1 arst_n = 1'h1;
        repeat (3) @(posedge core_clk);
        jis_ctl_model_inst.tlr();
        t_idcode();
        t_irlen();
        t_bypass();
        t_secure();
        end_of_test();
    end

    // hang guard
    initial begin
        #500000;
        failures++;
        end_of_test();
    end
endmodule : jis_tap_tb
`default_nettype wire
